// ---- hw/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;

    // register indices; the byte address is four times the index
    localparam logic [4:0] IDX_CONTROL  = 5'h00;
    localparam logic [4:0] IDX_ACCUM    = 5'h01;
    localparam logic [4:0] IDX_WINDOW   = 5'h04;
    localparam logic [4:0] IDX_INPUT    = 5'h06;
    localparam logic [4:0] IDX_COMMAND  = 5'h08;
    localparam logic [4:0] IDX_EVENT    = 5'h09;
    localparam logic [4:0] IDX_INTEN    = 5'h0A;
    localparam logic [4:0] IDX_INTFLAG  = 5'h0B;
    localparam logic [4:0] IDX_DEBUG    = 5'h0C;
    localparam logic [4:0] IDX_STAGING  = 5'h0D;
    localparam logic [4:0] IDX_RESULT   = 5'h10;
    localparam logic [4:0] IDX_LOWER    = 5'h12;
    localparam logic [4:0] IDX_UPPER    = 5'h14;

    // field positions
    localparam int FREE_RUN_BIT    = 0;
    localparam int BEGIN_BIT       = 0;
    localparam int EVENT_START_BIT = 0;
    localparam int DONE_BIT        = 0;
    localparam int MATCH_BIT       = 1;
    localparam int RUN_BREAK_BIT   = 0;

    // input selection codes
    localparam logic [4:0] SEL_PIN_LAST = 5'h07;
    localparam logic [4:0] SEL_PIN10    = 5'h0A;
    localparam logic [4:0] SEL_PIN11    = 5'h0B;
    localparam logic [4:0] SEL_VREF     = 5'h1D;
    localparam logic [4:0] SEL_GND      = 5'h1F;

    // limits and reset values
    localparam logic [9:0]  SAMPLE_MAX   = 10'h3FF;
    localparam logic [9:0]  SAMPLE_MIN   = 10'h000;
    localparam logic [15:0] ACC_MAX      = 16'hFFC0;
    localparam logic [2:0]  ACC_LOG2_MAX = 3'h6;
    localparam logic [7:0]  RESET_BYTE   = 8'h00;
    localparam logic [15:0] RESET_WORD   = 16'h0000;

    typedef enum logic [2:0] {
        WIN_NONE    = 3'b000,
        WIN_BELOW   = 3'b001,
        WIN_ABOVE   = 3'b010,
        WIN_INSIDE  = 3'b011,
        WIN_OUTSIDE = 3'b100
    } window_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_LAUNCH  = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;

endpackage

// ---- hw/adc_control_and_result_regs.sv ----
// Notes on behaviour
// RULE1 - selection used by a conversion is latched; later writes wait until it ends
// RULE2 - codes 0-7, 0x0A, 0x0B pins; 0x1D reference; 0x1F ground; others reserved
// RULE3 - writing one to begin bit starts a measurement, or first free-running one
// RULE4 - begin bit reads one while converting, cleared by hardware on completion
// RULE5 - with event start enabled an incoming event triggers a conversion
// RULE6 - window-match interrupt requested only while its enable bit 1 is set
// RULE7 - conversion-done interrupt requested only while its enable bit 0 is set
// RULE8 - at conversion end compare result to window mode, set match flag
// RULE9 - match flag cleared by writing one or reading result; zero ignored
// RULE10 - done flag set whenever a fresh result lands in the result register
// RULE11 - done flag cleared by writing one or reading result; zero ignored
// RULE12 - run-during-break zero halts and ignores events while CPU is stopped
// RULE13 - one shared readable, writable staging byte for all wide registers
// RULE14 - result low byte at base offset, high byte one address above
// RULE15 - a single sample saturates to 0x3FF above reference, 0x000 below ground
// RULE16 - accumulated result never exceeds 0xFFC0, at most 64 samples
// RULE17 - window modes: none, below, above, strictly inside, outside; others reserved
// RULE18 - thresholds apply to the final accumulated value, not each sample
// RULE19 - low read stages high byte; low write held until high write commits
module adc_control_and_result_regs
    import adc_ctrl_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        event_trigger,
    input  wire logic        cpu_halted,
    output logic             core_start,
    output logic      [4:0]  core_input,
    output logic             core_input_valid,
    input  wire logic        core_done,
    input  wire logic [9:0]  core_sample,
    input  wire logic        core_over,
    input  wire logic        core_under,
    output logic             irq
);

    // register state
    logic        free_run_q;
    logic [2:0]  acc_log2_q;
    logic [2:0]  window_mode_q;
    logic [4:0]  input_sel_q;
    logic        event_en_q;
    logic [1:0]  int_en_q;
    logic [1:0]  flags_q;
    logic [1:0]  flags_d;
    logic        run_break_q;
    logic [7:0]  staging_q;
    logic [15:0] result_q;
    logic [15:0] lower_q;
    logic [15:0] upper_q;
    logic [31:0] prdata_q;

    // conversion sequencer state
    conv_state_t state_q;
    conv_state_t state_d;
    logic [4:0]  active_sel_q;
    logic [6:0]  count_q;
    logic [15:0] acc_q;

    // bus decode
    wire        setup_ph  = psel & ~penable;
    wire        access_ph = psel & penable;
    wire [4:0]  idx       = paddr[6:2];
    wire        aligned   = (paddr[1:0] == 2'b00) & ~paddr[7];
    wire        wr        = access_ph & pwrite & pstrb[0];
    wire        rd        = access_ph & ~pwrite;
    wire        hit_ctl   = aligned & (idx == IDX_CONTROL);
    wire        hit_acc   = aligned & (idx == IDX_ACCUM);
    wire        hit_win   = aligned & (idx == IDX_WINDOW);
    wire        hit_in    = aligned & (idx == IDX_INPUT);
    wire        hit_cmd   = aligned & (idx == IDX_COMMAND);
    wire        hit_ev    = aligned & (idx == IDX_EVENT);
    wire        hit_ie    = aligned & (idx == IDX_INTEN);
    wire        hit_if    = aligned & (idx == IDX_INTFLAG);
    wire        hit_dbg   = aligned & (idx == IDX_DEBUG);
    wire        hit_stg   = aligned & (idx == IDX_STAGING);
    wire        hit_resl  = aligned & (idx == IDX_RESULT);
    wire        hit_resh  = aligned & (idx == IDX_RESULT + 5'h01);
    wire        hit_lol   = aligned & (idx == IDX_LOWER);
    wire        hit_loh   = aligned & (idx == IDX_LOWER + 5'h01);
    wire        hit_upl   = aligned & (idx == IDX_UPPER);
    wire        hit_uph   = aligned & (idx == IDX_UPPER + 5'h01);
    wire        wide_low  = hit_resl | hit_lol | hit_upl;
    wire        wide_high = hit_resh | hit_loh | hit_uph;
    wire        mapped    = hit_ctl | hit_acc | hit_win | hit_in | hit_cmd | hit_ev | hit_ie | hit_if
                          | hit_dbg | hit_stg | wide_low | wide_high;

    // read data is latched in the setup cycle, so every access answers with no wait state
    assign pready  = 1'b1;
    assign pslverr = access_ph & ~mapped;
    assign prdata  = prdata_q;

    // sequencer decode
    wire        halted    = cpu_halted & ~run_break_q;                          // [RULE12]
    wire        busy      = (state_q != ST_IDLE);
    wire        sw_begin  = wr & hit_cmd & pwdata[BEGIN_BIT];                  // [RULE3]
    wire        ev_begin  = event_en_q & event_trigger;                        // [RULE5]
    wire        begin_req = (sw_begin | ev_begin) & ~halted;                   // [RULE12]
    wire [2:0]  acc_eff   = (acc_log2_q > ACC_LOG2_MAX) ? ACC_LOG2_MAX : acc_log2_q; // [RULE16]
    wire [6:0]  last_cnt  = 7'((8'h01 << acc_eff) - 8'h01);
    wire [9:0]  sample    = core_over ? SAMPLE_MAX : (core_under ? SAMPLE_MIN : core_sample); // [RULE15]
    wire [15:0] acc_sum   = acc_q + {6'h00, sample};                           // [RULE16]
    wire        last      = (count_q == last_cnt);
    wire        finish    = (state_q == ST_CONVERT) & core_done & last;
    wire        match     = window_hit(window_mode_q, acc_sum, lower_q, upper_q); // [RULE18]

    assign core_start = (state_q == ST_LAUNCH) & ~halted;                      // [RULE12]
    assign core_input = active_sel_q;

    // input selection legality
    function automatic logic input_legal(input logic [4:0] code);
        input_legal = (code <= SEL_PIN_LAST) | (code == SEL_PIN10) | (code == SEL_PIN11)
                    | (code == SEL_VREF) | (code == SEL_GND);                  // [RULE2]
    endfunction

    // window comparison; reserved modes never match
    function automatic logic window_hit(input logic [2:0] mode, input logic [15:0] v,
                                        input logic [15:0] lo, input logic [15:0] hi);
        case (mode)                                                            // [RULE17]
            WIN_NONE:    window_hit = 1'b0;
            WIN_BELOW:   window_hit = (v < lo);
            WIN_ABOVE:   window_hit = (v > hi);
            WIN_INSIDE:  window_hit = (v > lo) & (v < hi);
            WIN_OUTSIDE: window_hit = (v < lo) | (v > hi);
            default:     window_hit = 1'b0;
        endcase
    endfunction

    // next state of the conversion sequencer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (begin_req)
                begin
                    state_d = ST_LAUNCH;                                       // [RULE3] [RULE5]
                end
            end
            ST_LAUNCH:
            begin
                if (!halted)
                begin
                    state_d = ST_CONVERT;
                end
            end
            ST_CONVERT:
            begin
                if (core_done)
                begin
                    if (!last || free_run_q)
                    begin
                        state_d = ST_LAUNCH;
                    end
                    else
                    begin
                        state_d = ST_IDLE;                                     // [RULE4]
                    end
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // selection is latched when a measurement begins and when one finishes, so mid-conversion writes wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active_sel_q     <= 5'h00;
            core_input_valid <= 1'b0;
        end
        else if ((state_q == ST_IDLE && begin_req) || finish)
        begin
            active_sel_q     <= input_sel_q;                                   // [RULE1]
            core_input_valid <= input_legal(input_sel_q);                      // [RULE2]
        end
    end

    // sample counter and accumulator, restarted at every measurement
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= 7'h00;
            acc_q   <= RESET_WORD;
        end
        else if (state_q == ST_IDLE || finish)
        begin
            count_q <= 7'h00;
            acc_q   <= RESET_WORD;
        end
        else if (state_q == ST_CONVERT && core_done)
        begin
            count_q <= count_q + 7'h01;
            acc_q   <= acc_sum;
        end
    end

    // final value lands in the result register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_q <= RESET_WORD;
        end
        else if (finish)
        begin
            result_q <= acc_sum;                                               // [RULE10] [RULE16]
        end
    end

    // sticky flags: a set in the same cycle as a clear wins
    wire       rd_result = rd & hit_resl;                                     // [RULE9] [RULE11]
    wire [1:0] flag_clr  = ({2{wr & hit_if}} & pwdata[1:0]) | {2{rd_result}};  // [RULE9] [RULE11]
    wire [1:0] flag_set  = {finish & match, finish};                           // [RULE8] [RULE10]
    assign flags_d = (flags_q & ~flag_clr) | flag_set;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_q <= 2'b00;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    // one level request from the enabled flags
    assign irq = |(flags_q & int_en_q);                                        // [RULE6] [RULE7]

    // plain control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            free_run_q    <= 1'b0;
            acc_log2_q    <= 3'h0;
            window_mode_q <= 3'h0;
            input_sel_q   <= 5'h00;
            event_en_q    <= 1'b0;
            int_en_q      <= 2'b00;
            run_break_q   <= 1'b0;
        end
        else if (wr)
        begin
            if (hit_ctl) free_run_q    <= pwdata[FREE_RUN_BIT];
            if (hit_acc) acc_log2_q    <= pwdata[2:0];
            if (hit_win) window_mode_q <= pwdata[2:0];
            if (hit_in)  input_sel_q   <= pwdata[4:0];
            if (hit_ev)  event_en_q    <= pwdata[EVENT_START_BIT];
            if (hit_ie)  int_en_q      <= pwdata[1:0];
            if (hit_dbg) run_break_q   <= pwdata[RUN_BREAK_BIT];
        end
    end

    // staging byte: direct access, low-byte writes, and low-byte reads of wide registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            staging_q <= RESET_BYTE;
        end
        else if (wr && (hit_stg || hit_lol || hit_upl))
        begin
            staging_q <= pwdata[7:0];                                          // [RULE13] [RULE19]
        end
        else if (rd && wide_low)
        begin
            staging_q <= hit_resl ? result_q[15:8] : (hit_lol ? lower_q[15:8] : upper_q[15:8]); // [RULE19]
        end
    end

    // thresholds commit both bytes on the high-byte write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lower_q <= RESET_WORD;
            upper_q <= RESET_WORD;
        end
        else if (wr)
        begin
            if (hit_loh) lower_q <= {pwdata[7:0], staging_q};                  // [RULE19]
            if (hit_uph) upper_q <= {pwdata[7:0], staging_q};                  // [RULE19]
        end
    end

    // read selection; high bytes of wide registers come from the staging byte
    wire [7:0] rd_byte =
        hit_ctl  ? {7'h00, free_run_q} :
        hit_acc  ? {5'h00, acc_log2_q} :
        hit_win  ? {5'h00, window_mode_q} :
        hit_in   ? {3'h0, input_sel_q} :
        hit_cmd  ? {7'h00, busy} :                                             // [RULE4]
        hit_ev   ? {7'h00, event_en_q} :
        hit_ie   ? {6'h00, int_en_q} :
        hit_if   ? {6'h00, flags_q} :
        hit_dbg  ? {7'h00, run_break_q} :
        hit_stg  ? staging_q :                                                 // [RULE13]
        hit_resl ? result_q[7:0] :                                             // [RULE14]
        hit_lol  ? lower_q[7:0] :
        hit_upl  ? upper_q[7:0] :
        wide_high ? staging_q :                                                // [RULE14] [RULE19]
        8'h00;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
        end
        else if (setup_ph && !pwrite)
        begin
            prdata_q <= {24'h00_0000, rd_byte};
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sel_hold_a:      assert property ((state_q != ST_IDLE) && !finish |=> $stable(core_input)) // [RULE1]
        else $error("selection changed inside a measurement");
    sel_reserved_a:  assert property ((core_input == 5'h08 || core_input == 5'h1C) |-> !core_input_valid) // [RULE2]
        else $error("reserved selection marked valid");
    begin_launch_a:  assert property (sw_begin && state_q == ST_IDLE && !halted |=> state_q == ST_LAUNCH) // [RULE3]
        else $error("begin write did not launch");
    busy_read_a:     assert property (setup_ph && !pwrite && hit_cmd |=> prdata_q[0] == $past(busy)) // [RULE4]
        else $error("begin bit does not show busy");
    event_launch_a:  assert property (ev_begin && state_q == ST_IDLE && !halted |=> state_q == ST_LAUNCH) // [RULE5]
        else $error("event did not launch");
    match_irq_a:     assert property (flags_q[MATCH_BIT] && int_en_q[1] |-> irq) // [RULE6]
        else $error("enabled match flag gives no interrupt");
    irq_gate_a:      assert property (int_en_q == 2'b00 |-> !irq) // [RULE7]
        else $error("interrupt without enable");
    done_flag_a:     assert property (finish |=> flags_q[DONE_BIT] && result_q == $past(acc_sum)) // [RULE10]
        else $error("finish did not set done flag and result");
    read_clear_a:    assert property (rd_result && !finish |=> flags_q == 2'b00) // [RULE9] [RULE11]
        else $error("result read did not clear flags");
    halt_freeze_a:   assert property (halted && state_q == ST_LAUNCH |-> !core_start ##1 state_q == ST_LAUNCH) // [RULE12]
        else $error("sequencer advanced while halted");
    acc_bound_a:     assert property (result_q <= ACC_MAX) // [RULE16]
        else $error("result above accumulation bound");

    single_conv_c:   cover property (state_q == ST_IDLE ##1 state_q == ST_LAUNCH ##[1:50] finish);
    match_irq_c:     cover property (finish && match && int_en_q[1] ##1 irq);
    free_run_c:      cover property (finish && free_run_q ##1 state_q == ST_LAUNCH);

endmodule

// ---- verification/adc_control_and_result_regs_bench.sv ----
module adc_control_and_result_regs_bench
    import adc_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk          = 1'b0;
    logic        presetn       = 1'b0;
    logic        psel          = 1'b0;
    logic        penable       = 1'b0;
    logic        pwrite        = 1'b0;
    logic [7:0]  paddr         = 8'h00;
    logic [31:0] pwdata        = 32'h00000000;
    logic [3:0]  pstrb         = 4'h0;
    logic        event_trigger = 1'b0;
    logic        cpu_halted    = 1'b0;
    logic        core_done     = 1'b0;
    logic [9:0]  core_sample   = 10'h000;
    logic        core_over     = 1'b0;
    logic        core_under    = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        core_start;
    logic [4:0]  core_input;
    logic        core_input_valid;
    logic        irq;
    logic [31:0] rdata;
    logic        last_err;
    int          bad_count       = 0;
    int          samples_checked = 0;

    adc_control_and_result_regs uut (
        .pclk             (pclk),
        .presetn          (presetn),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .pstrb            (pstrb),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .event_trigger    (event_trigger),
        .cpu_halted       (cpu_halted),
        .core_start       (core_start),
        .core_input       (core_input),
        .core_input_valid (core_input_valid),
        .core_done        (core_done),
        .core_sample      (core_sample),
        .core_over        (core_over),
        .core_under       (core_under),
        .irq              (irq)
    );

    // 20 MHz peripheral clock
    always #25 pclk = ~pclk;

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_pin(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; holds the request until pready is seen high at an edge
    task automatic apb(input logic wr_n, input logic [4:0] idx, input logic [7:0] wd, output logic [31:0] rd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_n;
        paddr   <= {1'b0, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        pstrb   <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        // no fixed wait: only the watchdog ends a transfer that never completes
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, rdata);
    endtask

    task automatic rd_chk(input logic [4:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00, rdata);
        check_reg(rdata, exp);
    endtask

    // low byte first so the high byte is staged coherently
    task automatic rd_result(input logic [15:0] exp);
        rd_chk(IDX_RESULT, {24'h000000, exp[7:0]});
        rd_chk(5'h11, {24'h000000, exp[15:8]});
    endtask

    // checked at the falling edge so the launching edge has settled
    task automatic wait_launch();
        int n;
        n = 0;
        do
            @(negedge pclk);
        while (core_start !== 1'b1 && n++ < 40);
        check_pin(core_start, 1'b1);
    endtask

    task automatic no_launch();
        logic seen;
        seen = 1'b0;
        repeat (8)
        begin
            @(negedge pclk);
            seen |= core_start;
        end
        check_pin(seen, 1'b0);
    endtask

    // answers in the cycle after launch; no trailing edge, so a relaunch is not missed
    task automatic feed(input logic [9:0] s, input logic ov, input logic un);
        @(posedge pclk);
        core_done   <= 1'b1;
        core_sample <= s;
        core_over   <= ov;
        core_under  <= un;
        @(posedge pclk);
        core_done   <= 1'b0;
        core_over   <= 1'b0;
        core_under  <= 1'b0;
    endtask

    task automatic convert(input logic [9:0] s, input logic ov, input logic un);
        wr(IDX_COMMAND, 8'h01);
        wait_launch();
        feed(s, ov, un);
    endtask

    task automatic irq_is(input logic exp);
        @(negedge pclk);
        check_pin(irq, exp);
    endtask

    task automatic pulse_event();
        @(posedge pclk);
        event_trigger <= 1'b1;
        @(posedge pclk);
        event_trigger <= 1'b0;
    endtask

    task automatic reset_values();
        logic [4:0] idx_list [8] = '{IDX_COMMAND, IDX_EVENT, IDX_INTEN, IDX_INTFLAG,
                                     IDX_DEBUG, IDX_STAGING, IDX_RESULT, 5'h11};
        foreach (idx_list[i])
            rd_chk(idx_list[i], 32'h00000000);
        apb(1'b0, 5'h1F, 8'h00, rdata);
        check_pin(last_err, 1'b1);
        check_reg(rdata, 32'h00000000);
        wr(IDX_STAGING, 8'h5A);
        rd_chk(IDX_STAGING, 32'h0000005A);
    endtask

    task automatic single_conv();
        wr(IDX_INPUT, 8'h0A);
        wr(IDX_COMMAND, 8'h01);
        wait_launch();
        wr(IDX_INPUT, 8'h03);
        rd_chk(IDX_COMMAND, 32'h00000001);
        check_reg({27'h0000000, core_input}, 32'h0000000A);
        feed(10'h155, 1'b0, 1'b0);
        rd_chk(IDX_COMMAND, 32'h00000000);
        rd_chk(IDX_INTFLAG, 32'h00000001);
        rd_chk(IDX_RESULT, 32'h00000055);
        rd_chk(IDX_STAGING, 32'h00000001);
        rd_chk(5'h11, 32'h00000001);
        rd_chk(IDX_INTFLAG, 32'h00000000);
    endtask

    task automatic input_codes();
        logic [4:0] codes [11] = '{5'h00, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B,
                                   5'h0C, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
        logic ok;
        foreach (codes[i])
        begin
            ok = codes[i] <= SEL_PIN_LAST || codes[i] == SEL_PIN10 || codes[i] == SEL_PIN11
                 || codes[i] == SEL_VREF || codes[i] == SEL_GND;
            wr(IDX_INPUT, {3'h0, codes[i]});
            wr(IDX_COMMAND, 8'h01);
            wait_launch();
            check_reg({27'h0000000, core_input}, {27'h0000000, codes[i]});
            check_pin(core_input_valid, ok);
            feed(10'h000, 1'b0, 1'b0);
        end
    endtask

    task automatic saturate();
        convert(10'h000, 1'b1, 1'b0);
        rd_result(16'h03FF);
        convert(10'h3FF, 1'b0, 1'b1);
        rd_result(16'h0000);
    endtask

    task automatic interrupts();
        wr(IDX_INTEN, 8'h01);
        convert(10'h100, 1'b0, 1'b0);
        irq_is(1'b1);
        wr(IDX_INTFLAG, 8'h00);
        rd_chk(IDX_INTFLAG, 32'h00000001);
        wr(IDX_INTEN, 8'h00);
        irq_is(1'b0);
        wr(IDX_INTFLAG, 8'h01);
        rd_chk(IDX_INTFLAG, 32'h00000000);
        wr(IDX_WINDOW, 8'h02);
        wr(IDX_UPPER, 8'hFF);
        wr(5'h15, 8'h00);
        wr(IDX_INTEN, 8'h02);
        convert(10'h100, 1'b0, 1'b0);
        rd_chk(IDX_INTFLAG, 32'h00000003);
        wr(IDX_INTFLAG, 8'h01);
        irq_is(1'b1);
        rd_chk(IDX_RESULT, 32'h00000000);
        rd_chk(IDX_INTFLAG, 32'h00000000);
        irq_is(1'b0);
        convert(10'h0FF, 1'b0, 1'b0);
        rd_chk(IDX_INTFLAG, 32'h00000001);
        wr(IDX_INTFLAG, 8'h03);
        wr(IDX_WINDOW, 8'h00);
        wr(IDX_INTEN, 8'h00);
    endtask

    // two samples of 0x200 sum to 0x400: inside 0x300..0x500 although each sample is below
    task automatic window_modes();
        logic [7:0]  modes [4] = '{8'h03, 8'h04, 8'h01, 8'h05};
        logic [31:0] flags [4] = '{32'h00000003, 32'h00000001, 32'h00000001, 32'h00000001};
        wr(IDX_LOWER, 8'h00);
        wr(5'h13, 8'h03);
        wr(IDX_UPPER, 8'h00);
        wr(5'h15, 8'h05);
        wr(IDX_ACCUM, 8'h01);
        foreach (modes[i])
        begin
            wr(IDX_WINDOW, modes[i]);
            wr(IDX_COMMAND, 8'h01);
            repeat (2)
            begin
                wait_launch();
                feed(10'h200, 1'b0, 1'b0);
            end
            rd_chk(IDX_INTFLAG, flags[i]);
            wr(IDX_INTFLAG, 8'h03);
        end
        wr(IDX_ACCUM, 8'h00);
        wr(IDX_WINDOW, 8'h00);
    endtask

    task automatic events();
        pulse_event();
        no_launch();
        wr(IDX_EVENT, 8'h01);
        pulse_event();
        wait_launch();
        feed(10'h001, 1'b0, 1'b0);
        cpu_halted <= 1'b1;
        pulse_event();
        no_launch();
        cpu_halted <= 1'b0;
        no_launch();
        wr(IDX_DEBUG, 8'h01);
        cpu_halted <= 1'b1;
        pulse_event();
        wait_launch();
        feed(10'h002, 1'b0, 1'b0);
        cpu_halted <= 1'b0;
        wr(IDX_EVENT, 8'h00);
        rd_result(16'h0002);
    endtask

    // 64 saturated samples reach the accumulator ceiling exactly
    task automatic accumulate();
        wr(IDX_ACCUM, 8'h06);
        wr(IDX_COMMAND, 8'h01);
        repeat (64)
        begin
            wait_launch();
            feed(10'h000, 1'b1, 1'b0);
        end
        rd_result(16'hFFC0);
        wr(IDX_ACCUM, 8'h00);
    endtask

    task automatic free_run();
        wr(IDX_DEBUG, 8'h00);
        wr(IDX_CONTROL, 8'h01);
        convert(10'h001, 1'b0, 1'b0);
        // halt lands as the relaunch begins, so the sequencer must freeze in launch
        cpu_halted <= 1'b1;
        no_launch();
        @(posedge pclk);
        cpu_halted <= 1'b0;
        wait_launch();
        wr(IDX_CONTROL, 8'h00);
        rd_chk(IDX_COMMAND, 32'h00000001);
        feed(10'h002, 1'b0, 1'b0);
        no_launch();
        rd_chk(IDX_COMMAND, 32'h00000000);
        rd_result(16'h0002);
    endtask

    // main sequence
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
        single_conv();
        input_codes();
        saturate();
        interrupts();
        window_modes();
        events();
        accumulate();
        free_run();
        conclude();
    end

    // the whole run needs well under a thousand cycles; this cuts a hang short
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        conclude();
    end
endmodule
